// ==== core/prm_mapper.sv ====
// Position range mapper: scaling, referencing, range placement and drag supervision.
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - Reject targets outside range, flag target error.
// - Defaults: mapping end 102400, limits 1200/101200.
// - Mapping end write derives both limits.
// - Positions and limits are signed.
// - Accept mapping end only around actual position.
// - Scaled bounds round to nearest integer.
// - 256 encoder rotations, 250 usable.
// - Steps per rotation equal 400*den/num.
// - Both scaling factors reset to 400.
// - Scaling factors limited to 1..10000.
// - Offset written directly or from desired position.
// - Direction bit picks counting sense.
// - Limits may be narrowed after derivation.
// - Flag drag error beyond threshold during run.
// - Zero threshold disables drag monitoring.
// - Scaling change rescales all user values.
// - Offset change shifts all user values.
// - Direction change restores offset, end, limits.
module prm_mapper
  import prm_pkg::*;
(
  // Clock and reset.
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Encoder and motion controller.
  input  wire logic [16:0]        enc_pos,
  input  wire logic               run_active,
  input  wire logic signed [31:0] profile_pos,
  output prm_run_type             run_cmd,
  output logic                    drag_error
);

  prm_regs_type       s;          // Registered state.
  prm_regs_type       next_s;     // Next state.
  logic signed [31:0] raw_dir;    // Encoder after direction selection.
  logic signed [31:0] pos_raw;    // Actual position, native steps, offset applied.
  logic signed [31:0] diff;       // Distance between commanded and actual position.
  logic signed [31:0] cv;         // Finished conversion result.
  logic signed [31:0] cx;         // Conversion operand.
  logic signed [31:0] mag;        // Magnitude of the operand.
  logic signed [31:0] lo_n;       // Candidate lower limit.
  logic signed [31:0] hi_n;       // Candidate upper limit.
  logic signed [31:0] ref_n;      // Candidate referencing offset.
  logic [13:0]        cmul;       // Conversion multiplier.
  logic [13:0]        cdiv;       // Conversion divisor.
  logic [14:0]        rem_sh;     // Shifted partial remainder.
  logic               go;         // Start a conversion.
  logic               map_ok;     // Address is a mapped register.

  // Values are kept in native encoder steps so that a change of scaling never
  // needs a sweep over stored values; an offset change shifts the stored range
  // once, and every user-facing value is converted on its way through the bus.
  always_comb begin
    raw_dir = s.dir ? (ENC_SPAN - $signed({15'h0, enc_pos}))
                    : $signed({15'h0, enc_pos});
    pos_raw = raw_dir - s.ref_raw;
    diff    = (profile_pos >= pos_raw) ? profile_pos - pos_raw : pos_raw - profile_pos;
  end

  // Bus engine, serial converter and parameter handling.
  always_comb begin
    next_s             = s;
    next_s.run.start   = 1'b0;
    go                 = 1'b0;
    cx                 = 32'sh0;
    cmul               = s.den;
    cdiv               = s.num;
    mag                = 32'sh0;
    cv                 = 32'sh0;
    rem_sh             = 15'h0;
    lo_n               = 32'sh0;
    hi_n               = 32'sh0;
    ref_n              = 32'sh0;
    map_ok             = (s.op_addr <= REG_STATUS) && (s.op_addr[1:0] == 2'h0);
    // Capture address and data in either order.
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held   = 1'b1;
      next_s.wdata    = s_axi_wdata;
      next_s.wstrb_ok = &s_axi_wstrb;
    end
    unique case (s.st)
      ST_IDLE: begin
        // A held write goes first; a read only enters while nothing is held.
        if (s.aw_held && s.w_held) begin
          go             = 1'b1;
          next_s.wr_op   = 1'b1;
          next_s.op_addr = s.waddr;
          cx             = $signed(s.wdata);
          cmul           = s.num;
          cdiv           = s.den;
        end else if (s_axi_arvalid && s.arready) begin
          go             = 1'b1;
          next_s.wr_op   = 1'b0;
          next_s.op_addr = s_axi_araddr;
          unique case (s_axi_araddr)
            REG_REF:    cx = s.ref_raw;
            REG_ACT:    cx = pos_raw;
            REG_MAPEND: cx = s.me_raw;
            REG_ULIM:   cx = s.lim_hi;
            REG_LLIM:   cx = s.lim_lo;
            REG_DRAG:   cx = s.drag_raw;
            REG_TARGET: cx = s.run.target;
            default:    cx = 32'sh0;
          endcase
        end
        if (go) begin
          // Rounded product: user = raw*den/num, raw = user*num/den.
          mag           = cx[31] ? -cx : cx;
          next_s.dv_acc = PROD_W'(mag) * PROD_W'(cmul) + PROD_W'(cdiv >> 1);
          next_s.dv_rem = 14'h0;
          next_s.dv_div = cdiv;
          next_s.dv_neg = cx[31];
          next_s.dv_cnt = DIV_STEPS;
          next_s.st     = ST_CONV;
        end
      end
      ST_CONV: begin
        if (s.dv_cnt != 6'h0) begin
          // One restoring division step per clock.
          rem_sh        = {s.dv_rem, s.dv_acc[PROD_W-1]};
          next_s.dv_acc = {s.dv_acc[PROD_W-2:0], 1'b0};
          if (rem_sh >= {1'b0, s.dv_div}) begin
            rem_sh           = rem_sh - {1'b0, s.dv_div};
            next_s.dv_acc[0] = 1'b1;
          end
          next_s.dv_rem = rem_sh[13:0];
          next_s.dv_cnt = s.dv_cnt - 6'h1;
        end else begin
          cv = s.dv_neg ? -$signed(s.dv_acc[31:0]) : $signed(s.dv_acc[31:0]);
          if (s.wr_op) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = (map_ok && s.wstrb_ok) ? RESP_OKAY : RESP_SLVERR;
            next_s.st      = ST_WRESP;
            if (map_ok && s.wstrb_ok) begin
              unique case (s.op_addr)
                REG_CTRL: begin
                  next_s.dir = s.wdata[0];
                  if (s.wdata[0] != s.dir) begin
                    next_s.ref_raw = REF_DEF;
                    next_s.me_raw  = ME_DEF;
                    next_s.lim_lo  = ME_DEF - LIM_LO_OFS;
                    next_s.lim_hi  = ME_DEF - LIM_HI_OFS;
                  end
                end
                REG_NUM, REG_DEN: begin
                  // Stored values are native, so rescaling is implicit.
                  if (s.wdata >= 32'(SCALE_MIN) && s.wdata <= 32'(SCALE_MAX)) begin
                    if (s.op_addr == REG_NUM) begin
                      next_s.num = s.wdata[13:0];
                    end else begin
                      next_s.den = s.wdata[13:0];
                    end
                  end else begin
                    next_s.st_par = 1'b1;
                  end
                end
                REG_REF, REG_ACT: begin
                  // The stored range moves with the offset, so it stays on the axle.
                  ref_n             = (s.op_addr == REG_REF) ? cv : raw_dir - cv;
                  next_s.ref_raw    = ref_n;
                  next_s.me_raw     = s.me_raw - ref_n + s.ref_raw;
                  next_s.lim_lo     = s.lim_lo - ref_n + s.ref_raw;
                  next_s.lim_hi     = s.lim_hi - ref_n + s.ref_raw;
                  next_s.run.target = s.run.target - ref_n + s.ref_raw;
                end
                REG_MAPEND: begin
                  lo_n = cv - LIM_LO_OFS;
                  hi_n = cv - LIM_HI_OFS;
                  // Window check: one step of slack covers rounding.
                  if (pos_raw >= lo_n - 32'sh1 && pos_raw <= hi_n + 32'sh1) begin
                    next_s.me_raw = cv;
                    next_s.lim_lo = lo_n;
                    next_s.lim_hi = hi_n;
                  end else begin
                    next_s.st_par = 1'b1;
                  end
                end
                REG_ULIM: begin
                  if (cv <= s.me_raw - LIM_HI_OFS && cv >= s.lim_lo) begin
                    next_s.lim_hi = cv;
                  end else begin
                    next_s.st_par = 1'b1;
                  end
                end
                REG_LLIM: begin
                  if (cv >= s.me_raw - LIM_LO_OFS && cv <= s.lim_hi) begin
                    next_s.lim_lo = cv;
                  end else begin
                    next_s.st_par = 1'b1;
                  end
                end
                REG_DRAG: begin
                  if (cv >= 32'sh0) begin
                    next_s.drag_raw = cv;
                  end else begin
                    next_s.st_par = 1'b1;
                  end
                end
                REG_TARGET: begin
                  // Limits always lie inside the margins, so this also guards them.
                  if (cv >= s.lim_lo && cv <= s.lim_hi) begin
                    next_s.run.start  = 1'b1;
                    next_s.run.target = cv;
                  end else begin
                    next_s.st_tgt = 1'b1;
                  end
                end
                REG_STATUS: begin
                  // Write one to clear; a drag set in the same cycle overrides the clear.
                  if (s.wdata[ST_DRAG_BIT]) next_s.st_drag = 1'b0;
                  if (s.wdata[ST_TGT_BIT]) next_s.st_tgt = 1'b0;
                  if (s.wdata[ST_PAR_BIT]) next_s.st_par = 1'b0;
                end
                default: begin
                end
              endcase
            end
          end else begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = map_ok ? RESP_OKAY : RESP_SLVERR;
            next_s.st     = ST_RRESP;
            unique case (s.op_addr)
              REG_CTRL:   next_s.rdata = {31'h0, s.dir};
              REG_NUM:    next_s.rdata = {18'h0, s.num};
              REG_DEN:    next_s.rdata = {18'h0, s.den};
              REG_STATUS: next_s.rdata = {28'h0, run_active, s.st_par, s.st_tgt, s.st_drag};
              REG_REF, REG_ACT, REG_MAPEND, REG_ULIM, REG_LLIM, REG_DRAG, REG_TARGET:
                next_s.rdata = cv;
              default:    next_s.rdata = 32'h0;
            endcase
          end
        end
      end
      ST_WRESP: begin
        if (s_axi_bready) begin
          next_s.bvalid = 1'b0;
          next_s.st     = ST_IDLE;
        end
      end
      ST_RRESP: begin
        if (s_axi_rready) begin
          next_s.rvalid = 1'b0;
          next_s.st     = ST_IDLE;
        end
      end
    endcase
    // Drag supervision; its set overrides a clear in the same cycle.
    if (run_active && s.drag_raw != 32'sh0 && diff > s.drag_raw) begin
      next_s.st_drag = 1'b1;
    end
    // Ready flags are registered so every bus output comes from a flip-flop.
    next_s.awready = (next_s.st == ST_IDLE) && !next_s.aw_held;
    next_s.wready  = (next_s.st == ST_IDLE) && !next_s.w_held;
    next_s.arready = (next_s.st == ST_IDLE) && !next_s.aw_held && !next_s.w_held;
  end

  // State register; reset loads the factory_default_state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.num      <= SCALE_DEF;
      s.den      <= SCALE_DEF;
      s.ref_raw  <= REF_DEF;
      s.me_raw   <= ME_DEF;
      s.lim_lo   <= ME_DEF - LIM_LO_OFS;
      s.lim_hi   <= ME_DEF - LIM_HI_OFS;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rdata   = s.rdata;
  assign run_cmd       = s.run;
  assign drag_error    = s.st_drag;

  // Checks on the mapper's own behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_target_in_range;
    s.run.start |-> (s.run.target >= s.lim_lo) && (s.run.target <= s.lim_hi);
  endproperty
  a_target_in_range: assert property (p_target_in_range)
    else $error("Run started outside the limits.");
  property p_limits_follow_end;
    $changed(s.me_raw) && $past(s.dir) == s.dir && $stable(s.ref_raw) |->
      s.lim_lo == s.me_raw - LIM_LO_OFS && s.lim_hi == s.me_raw - LIM_HI_OFS;
  endproperty
  a_limits_follow_end: assert property (p_limits_follow_end)
    else $error("Limits not derived from mapping end.");
  property p_end_window;
    $changed(s.me_raw) && $past(s.dir) == s.dir && $stable(s.ref_raw) |->
      $past(pos_raw) >= s.lim_lo - 32'sh1 && $past(pos_raw) <= s.lim_hi + 32'sh1;
  endproperty
  a_end_window: assert property (p_end_window)
    else $error("Mapping end accepted outside window.");
  property p_scale_range;
    s.num >= SCALE_MIN && s.num <= SCALE_MAX && s.den >= SCALE_MIN && s.den <= SCALE_MAX;
  endproperty
  a_scale_range: assert property (p_scale_range)
    else $error("Scaling factor out of range.");
  property p_drag_set;
    run_active && s.drag_raw != 32'sh0 && diff > s.drag_raw |=> s.st_drag;
  endproperty
  a_drag_set: assert property (p_drag_set)
    else $error("Drag error not flagged.");
  property p_drag_off;
    $rose(s.st_drag) |-> $past(s.drag_raw) != 32'sh0 && $past(run_active);
  endproperty
  a_drag_off: assert property (p_drag_off)
    else $error("Drag error set while monitoring off.");
  property p_dir_restore;
    $changed(s.dir) |-> s.me_raw == ME_DEF && s.ref_raw == REF_DEF &&
      s.lim_lo == ME_DEF - LIM_LO_OFS && s.lim_hi == ME_DEF - LIM_HI_OFS;
  endproperty
  a_dir_restore: assert property (p_dir_restore)
    else $error("Direction change did not restore defaults.");
  property p_narrow_only;
    s.lim_lo >= s.me_raw - LIM_LO_OFS && s.lim_hi <= s.me_raw - LIM_HI_OFS;
  endproperty
  a_narrow_only: assert property (p_narrow_only)
    else $error("Limit widened past derived range.");
  property p_refuse_keeps;
    $rose(s.st_par) |-> $stable(s.me_raw) && $stable(s.lim_lo) && $stable(s.lim_hi);
  endproperty
  a_refuse_keeps: assert property (p_refuse_keeps)
    else $error("Refused write changed the range.");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready |-> ##[1:120] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("Write response missing.");

  c_run_start: cover property (s.run.start);
  c_target_err: cover property ($rose(s.st_tgt));
  c_end_refused: cover property ($rose(s.st_par));
  c_drag: cover property ($rose(s.st_drag));

endmodule : prm_mapper

// ==== shared/prm_pkg.sv ====
// Package of constants, register offsets and types for the position range mapper.
package prm_pkg;

  // Encoder geometry in native steps; the encoder resolves 400 steps per rotation.
  localparam logic signed [31:0] STEPS_PER_ROT = 32'sh0000_0190;
  localparam logic signed [31:0] ENC_ROT       = 32'sh0000_0100;
  localparam logic signed [31:0] MARGIN_ROT    = 32'sh0000_0003;
  localparam logic signed [31:0] USE_ROT       = ENC_ROT - 2 * MARGIN_ROT;
  localparam logic signed [31:0] ENC_SPAN      = ENC_ROT * STEPS_PER_ROT;
  // Distance below the mapping end of the upper and of the lower limit.
  localparam logic signed [31:0] LIM_HI_OFS    = MARGIN_ROT * STEPS_PER_ROT;
  localparam logic signed [31:0] LIM_LO_OFS    = (ENC_ROT - MARGIN_ROT) * STEPS_PER_ROT;

  // Values of the factory_default_state, positions in native steps; scaling factor range.
  localparam logic signed [31:0] ME_DEF  = ENC_SPAN;
  localparam logic signed [31:0] REF_DEF = 32'sh0000_0000;
  localparam logic [13:0]        SCALE_DEF = 14'h0190;
  localparam logic [13:0]        SCALE_MIN = 14'h0001;
  localparam logic [13:0]        SCALE_MAX = 14'h2710;

  // Serial divider length: one step per product bit.
  localparam int unsigned        PROD_W    = 46;
  localparam logic [5:0]         DIV_STEPS = 6'h2E;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_NUM    = 8'h04;
  localparam logic [7:0] REG_DEN    = 8'h08;
  localparam logic [7:0] REG_REF    = 8'h0C;
  localparam logic [7:0] REG_ACT    = 8'h10;
  localparam logic [7:0] REG_MAPEND = 8'h14;
  localparam logic [7:0] REG_ULIM   = 8'h18;
  localparam logic [7:0] REG_LLIM   = 8'h1C;
  localparam logic [7:0] REG_DRAG   = 8'h20;
  localparam logic [7:0] REG_TARGET = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;

  // Status bit positions.
  localparam int unsigned ST_DRAG_BIT = 0;
  localparam int unsigned ST_TGT_BIT  = 1;
  localparam int unsigned ST_PAR_BIT  = 2;
  localparam int unsigned ST_RUN_BIT  = 3;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bus engine states.
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WRESP, ST_RRESP} prm_state_type;

  // Run command handed to the motion controller.
  typedef struct packed {
    logic               start;
    logic signed [31:0] target;
  } prm_run_type;

  // Whole state of the mapper.
  typedef struct packed {
    prm_state_type      st;
    logic               aw_held;
    logic               w_held;
    logic               wr_op;
    logic [7:0]         waddr;
    logic [7:0]         op_addr;
    logic [31:0]        wdata;
    logic               wstrb_ok;
    logic               awready;
    logic               wready;
    logic               arready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
    logic               dir;
    logic [13:0]        num;
    logic [13:0]        den;
    logic signed [31:0] ref_raw;
    logic signed [31:0] me_raw;
    logic signed [31:0] lim_lo;
    logic signed [31:0] lim_hi;
    logic signed [31:0] drag_raw;
    logic               st_drag;
    logic               st_tgt;
    logic               st_par;
    prm_run_type        run;
    logic [PROD_W-1:0]  dv_acc;
    logic [13:0]        dv_rem;
    logic [13:0]        dv_div;
    logic               dv_neg;
    logic [5:0]         dv_cnt;
  } prm_regs_type;

endpackage : prm_pkg

// ==== dv/prm_ctrl_model.sv ====
// Register-bus master standing in for the IO controller.
`timescale 1ns/1ps
module prm_ctrl_model (
  // Clock.
  input  wire logic        aclk,
  // Write channels.
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels.
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Bus idles at time zero, so no request exists before reset ends.
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // One write; each half is dropped and scrambled once it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // One read; rready stays up until the data is seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : prm_ctrl_model

// ==== dv/test_prm_mapper.sv ====
// Self-checking bench for the position range mapper.
`timescale 1ns/1ps
module test_prm_mapper
  import prm_pkg::*;
;
  // Ports named as at the design, so that .* joins them.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  // Encoder starts at mid range with no run.
  logic [16:0] enc_pos = 17'h0C800;
  logic run_active = 1'b0;
  logic signed [31:0] profile_pos = 32'sh0000C800;
  prm_run_type run_cmd;
  logic drag_error;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int starts = 0;
  prm_mapper dut (.*);
  prm_ctrl_model ctl (.*);
  always #2.5 aclk = ~aclk;
  // Run start pulses last one cycle, so they are counted as they pass.
  always @(posedge aclk) begin
    if (run_cmd.start) begin
      starts <= starts + 1;
    end
  end
  // Verdict and end of run.
  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Hang guard, far above the roughly 2000 cycles of the run.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Write and compare the response.
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    ctl.wr(a, d, r);
    chk({30'h0, r}, {30'h0, e});
  endtask : w
  // Read and compare the data.
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    ctl.rd(a, d, r);
    chk(d, e);
  endtask : rc
  task automatic t_reset();
    rc(REG_MAPEND, 32'h00019000);
    rc(REG_LLIM, 32'h000004B0);
    rc(REG_ULIM, 32'h00018B50);
    rc(REG_NUM, 32'h00000190);
    rc(REG_DEN, 32'h00000190);
  endtask : t_reset
  // Both acceptance extremes, then one step past the slack.
  task automatic t_mapend();
    w(REG_MAPEND, 32'h00025350, RESP_OKAY);
    rc(REG_LLIM, 32'h0000C800);
    w(REG_MAPEND, 32'h0000CCB0, RESP_OKAY);
    rc(REG_LLIM, 32'hFFFF4160);
    rc(REG_ULIM, 32'h0000C800);
    w(REG_MAPEND, 32'h0000CCAE, RESP_OKAY);
    rc(REG_MAPEND, 32'h0000CCB0);
    rc(REG_STATUS, 32'h00000004);
    w(REG_STATUS, 32'h00000004, RESP_OKAY);
  endtask : t_mapend
  // Target above the upper limit, then exactly on it.
  task automatic t_target();
    w(REG_TARGET, 32'h0000EA60, RESP_OKAY);
    rc(REG_STATUS, 32'h00000002);
    chk(starts, 32'h0);
    w(REG_TARGET, 32'h0000C800, RESP_OKAY);
    chk(run_cmd.target, 32'h0000C800);
    // The pulse is counted at the edge that returns the write.
    @(posedge aclk);
    chk(starts, 32'h1);
    w(REG_STATUS, 32'h00000002, RESP_OKAY);
  endtask : t_target
  // Run lagging by 500 steps; threshold zero, then 100.
  task automatic t_drag();
    @(posedge aclk);
    profile_pos <= 32'sh0000C9F4;
    run_active <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, drag_error}, 32'h0);
    w(REG_DRAG, 32'h00000064, RESP_OKAY);
    // The flag rises one edge after the threshold lands.
    @(posedge aclk);
    chk({31'h0, drag_error}, 32'h1);
    rc(REG_STATUS, 32'h00000009);
    @(posedge aclk);
    run_active <= 1'b0;
    w(REG_STATUS, 32'h00000001, RESP_OKAY);
  endtask : t_drag
  // Desired actual position of zero shifts every user value.
  task automatic t_ref();
    w(REG_ACT, 32'h0, RESP_OKAY);
    rc(REG_REF, 32'h0000C800);
    rc(REG_ACT, 32'h0);
    rc(REG_MAPEND, 32'h000004B0);
    rc(REG_ULIM, 32'h0);
    rc(REG_TARGET, 32'h0);
  endtask : t_ref
  // Reversed sense with the encoder near its low end.
  task automatic t_dir();
    @(posedge aclk);
    enc_pos <= 17'h004B0;
    // Direction goes after the range settings, as a change restores the range.
    w(REG_CTRL, 32'h1, RESP_OKAY);
    rc(REG_REF, 32'h0);
    rc(REG_MAPEND, 32'h00019000);
    rc(REG_LLIM, 32'h000004B0);
    rc(REG_ACT, 32'h00018B50);
  endtask : t_dir
  // Doubled denominator, then numerator just outside both ends of its range.
  task automatic t_scale();
    w(REG_DEN, 32'h00000320, RESP_OKAY);
    rc(REG_ACT, 32'h000316A0);
    rc(REG_MAPEND, 32'h00032000);
    w(REG_NUM, 32'h0, RESP_OKAY);
    w(REG_NUM, 32'h00002711, RESP_OKAY);
    rc(REG_NUM, 32'h00000190);
    rc(REG_STATUS, 32'h00000004);
  endtask : t_scale
  // Unmapped place is refused both ways.
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    ctl.rd(8'h30, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    w(8'h30, 32'h1, RESP_SLVERR);
  endtask : t_bus
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mapend();
    t_target();
    t_drag();
    t_ref();
    t_dir();
    t_scale();
    t_bus();
    print_verdict();
  end
endmodule : test_prm_mapper
